// ==== pkg/t1tcc_pkg.sv ====
// Package of register map, field layout and constants for the T1 controls
//----------------------------------------------------------------------------
//----------------------------------------------------------------------------
package t1tcc_pkg;

	//--------------------------------------------------------------------------
	// Register indices; byte address is four times the index
	//--------------------------------------------------------------------------
	localparam logic [7:0] TX_CTRL_ONE_IDX  = 8'h35;
	localparam logic [7:0] TX_CTRL_TWO_IDX  = 8'h36;
	localparam logic [7:0] COMMON_CTRL_IDX  = 8'h37;
	localparam logic [7:0] STATUS_IDX       = 8'h40;

	//--------------------------------------------------------------------------
	// Reset values
	//--------------------------------------------------------------------------
	localparam logic [7:0] TX_CTRL_ONE_RST  = 8'h00;
	localparam logic [7:0] TX_CTRL_TWO_RST  = 8'h00;
	localparam logic [7:0] COMMON_CTRL_RST  = 8'h00;

	//--------------------------------------------------------------------------
	// Transmit control one fields
	//--------------------------------------------------------------------------
	localparam int CLK_FALLBACK_BIT  = 7;
	localparam int FRAMING_PT_BIT    = 6;
	localparam int CRC_PT_BIT        = 5;
	localparam int SIG_INSERT_BIT    = 4;
	localparam int GLOBAL_STUFF_BIT  = 3;
	localparam int LINK_SRC_BIT      = 2;
	localparam int BLUE_BIT          = 1;
	localparam int YELLOW_BIT        = 0;

	//--------------------------------------------------------------------------
	// Transmit control two fields
	//--------------------------------------------------------------------------
	localparam int PIN_TEST_HI_BIT   = 7;
	localparam int PIN_TEST_LO_BIT   = 6;
	localparam int SLOT_XCHG_BIT     = 5;
	localparam int SYNC_DW_BIT       = 4;
	localparam int SYNC_RATE_BIT     = 3;
	localparam int SYNC_DIR_BIT      = 2;
	localparam int YEL_FORMAT_BIT    = 1;
	localparam int ZERO_SUPP_BIT     = 0;

	//--------------------------------------------------------------------------
	// Common control one fields
	//--------------------------------------------------------------------------
	localparam int TX_STORE_BIT      = 7;
	localparam int LOCAL_LOOP_BIT    = 6;
	localparam int RX_SIG_ONES_BIT   = 5;
	localparam int REMOTE_LOOP_BIT   = 4;
	localparam int BP_CLK_RATE_BIT   = 3;

	//--------------------------------------------------------------------------
	// Channel byte bit positions, bit 1 is the MSB on the line
	//--------------------------------------------------------------------------
	localparam int CH_BIT2_POS       = 6;
	localparam int CH_BIT7_POS       = 1;
	localparam int CH_BIT8_POS       = 0;

	//--------------------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------------------
	localparam int CLK_LOSS_CYCLES   = 64;

	//--------------------------------------------------------------------------
	// Enumerations
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		PT_NORMAL = 2'b00,
		PT_FLOAT  = 2'b01,
		PT_LOW    = 2'b10,
		PT_HIGH   = 2'b11
	} t1tcc_test_e;

	typedef enum logic [1:0] {
		FB_FRAMING = 2'b00,
		FB_CRC     = 2'b01,
		FB_LINK    = 2'b10,
		FB_SIGNAL  = 2'b11
	} t1tcc_fbit_e;

endpackage

// ==== verilog/t1tcc_clk_mon.sv ====
// Transmit clock pin activity monitor with loss detection
`timescale 1ns/10ps
module t1tcc_clk_mon
	import t1tcc_pkg::*;
#(
	parameter int LOSS_CYCLES = CLK_LOSS_CYCLES
) (
	// System
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Monitored pin and result
	input  wire logic clk_pin_i,
	output logic      lost_o
);

	localparam int CW = $clog2(LOSS_CYCLES + 1);
	localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

	logic          sync1_q;
	logic          sync2_q;
	logic          prev_q;
	logic [CW-1:0] idle_q;
	logic [CW-1:0] idle_d;
	wire           toggled = sync2_q ^ prev_q;

	// Idle counter saturates at the limit, any edge restarts it
	assign idle_d = toggled ? '0 : (idle_q == LIMIT ? idle_q : idle_q + 1'b1);
	assign lost_o = (idle_q == LIMIT);

	//--------------------------------------------------------------------------
	// Two-stage sync, then edge detect on the second stage only
	//--------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q  <= 1'b0;
			idle_q  <= '0;
		end else begin
			sync1_q <= clk_pin_i;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
			idle_q  <= idle_d;
		end
	end

endmodule

// ==== verilog/t1tcc_top.sv ====
// Transmit and common control register bank with its data-path controls
`timescale 1ns/10ps
module t1tcc_top
	import t1tcc_pkg::*;
#(
	parameter int LOSS_CYCLES = CLK_LOSS_CYCLES
) (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Pins from outside
	input  wire logic        transmit_clock_i,
	input  wire logic        tx_link_pin_i,
	input  wire logic        tx_sync_pin_i,
	// Transmit channel stream from the formatter
	input  wire logic        tx_byte_valid_i,
	input  wire logic [7:0]  tx_serial_in_i,
	input  wire logic        chan_transparent_i,
	input  wire logic        sig_frame_i,
	input  wire logic        tx_sig_bit_i,
	// Transmit F-bit stream from the formatter
	input  wire logic        fbit_valid_i,
	input  wire logic [1:0]  fbit_kind_i,
	input  wire logic        fbit_serial_i,
	input  wire logic        fbit_internal_i,
	input  wire logic        tx_link_data_reg_i,
	input  wire logic        frame12_i,
	// Frame timing from the formatter
	input  wire logic        frame_start_i,
	input  wire logic        mframe_start_i,
	// Receive stream from the line side
	input  wire logic        rx_byte_valid_i,
	input  wire logic [7:0]  rx_line_byte_i,
	input  wire logic        rx_sig_frame_i,
	// Line outputs
	output logic [7:0]       line_out_byte_o,
	output logic             line_out_fbit_o,
	output logic [7:0]       rx_serial_out_o,
	// Sync pin
	output logic             tx_sync_pin_o,
	output logic             tx_sync_pin_oe_n_o,
	output logic             tx_sync_in_o,
	// Pin enables
	output logic             out_oe_n_o,
	output logic             host_port_oe_n_o,
	// Controls to neighbouring blocks
	output logic             use_rx_clock_o,
	output logic             tx_slot_interchange_en_o,
	output logic             tx_store_en_o,
	output logic             local_loop_en_o,
	output logic             remote_loop_en_o,
	output logic             backplane_clock_rate_sel_o
);

	//--------------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------------
	logic [7:0]  tcr_one_q;
	logic [7:0]  tcr_two_q;
	logic [7:0]  ccr_one_q;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        link1_q;
	logic        link2_q;
	logic        sync1_q;
	logic        sync2_q;
	logic [7:0]  line_byte_q;
	logic        line_fbit_q;
	logic [7:0]  rx_out_q;
	logic        sync_out_q;
	logic        sync_ext_q;
	logic        clk_lost;
	t1tcc_test_e pin_test;

	//--------------------------------------------------------------------------
	// Pin test forcing of a data byte
	//--------------------------------------------------------------------------
	function automatic logic [7:0] pin_force(logic [7:0] v, t1tcc_test_e m);
		logic [7:0] r;
		r = v;
		if (m == PT_LOW) begin
			r = 8'h00;
		end else if (m == PT_HIGH) begin
			r = 8'hff;
		end
		return r;
	endfunction

	//--------------------------------------------------------------------------
	// Field extraction
	//--------------------------------------------------------------------------
	wire clock_loss_fallback_sel  = tcr_one_q[CLK_FALLBACK_BIT];
	wire framing_bit_passthru     = tcr_one_q[FRAMING_PT_BIT];
	wire crc_passthru             = tcr_one_q[CRC_PT_BIT];
	wire signalling_insert_en     = tcr_one_q[SIG_INSERT_BIT];
	wire global_zero_stuff        = tcr_one_q[GLOBAL_STUFF_BIT];
	wire tx_link_source_sel       = tcr_one_q[LINK_SRC_BIT];
	wire blue_alarm_send          = tcr_one_q[BLUE_BIT];
	wire yellow_alarm_send        = tcr_one_q[YELLOW_BIT];
	wire tx_sync_double_wide      = tcr_two_q[SYNC_DW_BIT];
	wire tx_sync_rate_sel         = tcr_two_q[SYNC_RATE_BIT];
	wire tx_sync_direction        = tcr_two_q[SYNC_DIR_BIT];
	wire tx_superframe_alarm_fmt  = tcr_two_q[YEL_FORMAT_BIT];
	wire zero_suppression_en      = tcr_two_q[ZERO_SUPP_BIT];
	wire rx_signalling_force_ones = ccr_one_q[RX_SIG_ONES_BIT];

	// Two test bits form one mode code
	assign pin_test = t1tcc_test_e'({tcr_two_q[PIN_TEST_HI_BIT],
		tcr_two_q[PIN_TEST_LO_BIT]});

	//--------------------------------------------------------------------------
	// Bus decode
	//--------------------------------------------------------------------------
	wire [7:0] idx     = adr_i[9:2];
	wire       req     = cyc_i & stb_i & ~ack_q;
	wire       wr_lane = req & we_i & sel_i[0];
	wire       wr_one  = wr_lane & (idx == TX_CTRL_ONE_IDX);
	wire       wr_two  = wr_lane & (idx == TX_CTRL_TWO_IDX);
	wire       wr_ccr  = wr_lane & (idx == COMMON_CTRL_IDX);
	wire [7:0] status  = {5'h00, sync2_q, use_rx_clock_o, clk_lost};
	// Unmapped indices read as zero and still acknowledge
	wire [7:0] rd_sel  = (idx == TX_CTRL_ONE_IDX) ? tcr_one_q :
	                     (idx == TX_CTRL_TWO_IDX) ? tcr_two_q :
	                     (idx == COMMON_CTRL_IDX) ? ccr_one_q :
	                     (idx == STATUS_IDX)      ? status    : 8'h00;

	assign ack_o = ack_q;
	assign dat_o = rdata_q;

	//--------------------------------------------------------------------------
	// Registers and single-cycle answer
	//--------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tcr_one_q <= TX_CTRL_ONE_RST;
			tcr_two_q <= TX_CTRL_TWO_RST;
			ccr_one_q <= COMMON_CTRL_RST;
			ack_q     <= 1'b0;
			rdata_q   <= 32'h0000_0000;
		end else begin
			ack_q   <= req;
			rdata_q <= req ? {24'h00_0000, rd_sel} : 32'h0000_0000;
			if (wr_one) begin
				tcr_one_q <= dat_i[7:0];
			end
			if (wr_two) begin
				tcr_two_q <= dat_i[7:0];
			end
			if (wr_ccr) begin
				ccr_one_q <= dat_i[7:0];
			end
		end
	end

	//--------------------------------------------------------------------------
	// Clock loss watch and fallback
	//--------------------------------------------------------------------------
	t1tcc_clk_mon #(
		.LOSS_CYCLES (LOSS_CYCLES)
	) u_clk_mon (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.clk_pin_i (transmit_clock_i),
		.lost_o    (clk_lost)
	);

	// Only switches while the fallback is armed
	assign use_rx_clock_o = clock_loss_fallback_sel & clk_lost;

	//--------------------------------------------------------------------------
	// Plain control outputs
	//--------------------------------------------------------------------------
	assign tx_slot_interchange_en_o   = tcr_two_q[SLOT_XCHG_BIT];
	assign tx_store_en_o              = ccr_one_q[TX_STORE_BIT];
	assign local_loop_en_o            = ccr_one_q[LOCAL_LOOP_BIT];
	assign remote_loop_en_o           = ccr_one_q[REMOTE_LOOP_BIT];
	// 0 line-rate backplane, 1 E1-rate backplane
	assign backplane_clock_rate_sel_o = ccr_one_q[BP_CLK_RATE_BIT];

	//--------------------------------------------------------------------------
	// Pin synchronisers for link and sync inputs
	//--------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link1_q <= 1'b0;
			link2_q <= 1'b0;
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			link1_q <= tx_link_pin_i;
			link2_q <= link1_q;
			sync1_q <= tx_sync_pin_i;
			sync2_q <= sync1_q;
		end
	end

	//--------------------------------------------------------------------------
	// Transmit channel byte path
	//--------------------------------------------------------------------------
	// Remote loop replaces serial input with recovered line data
	wire [7:0] src_byte = remote_loop_en_o ? rx_line_byte_i
	                                       : tx_serial_in_i;
	wire       all_zero = (src_byte == 8'h00);
	// Global stuffing overrides per-channel transparency
	wire       do_stuff = zero_suppression_en & all_zero &
	                      (global_zero_stuff | ~chan_transparent_i);
	wire       do_sig   = signalling_insert_en & sig_frame_i &
	                      ~chan_transparent_i;
	wire       yel_bit2 = yellow_alarm_send & ~tx_superframe_alarm_fmt;
	logic [7:0] fmt_byte;

	// Loopback bytes keep their line content, except that blue alarm still forces all ones
	always_comb begin
		fmt_byte = src_byte;
		if (!remote_loop_en_o) begin
			if (do_stuff) begin
				fmt_byte[CH_BIT7_POS] = 1'b1;
			end
			if (do_sig) begin
				fmt_byte[CH_BIT8_POS] = tx_sig_bit_i;
			end
			if (yel_bit2) begin
				fmt_byte[CH_BIT2_POS] = 1'b0;
			end
		end
		if (blue_alarm_send) begin
			fmt_byte = 8'hff;
		end
	end

	//--------------------------------------------------------------------------
	// Transmit F-bit selection
	//--------------------------------------------------------------------------
	wire link_bit = tx_link_source_sel ? link2_q : tx_link_data_reg_i;
	logic fbit_sel;

	// Pass-through bits come straight from the serial input
	always_comb begin
		unique case (t1tcc_fbit_e'(fbit_kind_i))
			FB_FRAMING: fbit_sel = framing_bit_passthru ? fbit_serial_i
			                                            : fbit_internal_i;
			FB_CRC:     fbit_sel = crc_passthru ? fbit_serial_i
			                                    : fbit_internal_i;
			FB_LINK:    fbit_sel = link_bit;
			FB_SIGNAL:  fbit_sel = fbit_internal_i;
		endcase
		// Superframe yellow rides on the frame 12 S-bit
		if (yellow_alarm_send && tx_superframe_alarm_fmt && frame12_i &&
			t1tcc_fbit_e'(fbit_kind_i) == FB_SIGNAL) begin
			fbit_sel = 1'b1;
		end
		if (blue_alarm_send) begin
			fbit_sel = 1'b1;
		end
	end

	//--------------------------------------------------------------------------
	// Receive path with local loop and signalling forcing
	//--------------------------------------------------------------------------
	// Local loop hands transmitted bytes back, line transmit goes on
	wire [7:0] rx_src  = local_loop_en_o ? fmt_byte : rx_line_byte_i;
	wire       rx_take = local_loop_en_o ? tx_byte_valid_i : rx_byte_valid_i;
	wire [7:0] rx_fmt  = {rx_src[7:1], rx_src[0] |
	                      (rx_signalling_force_ones & rx_sig_frame_i)};

	//--------------------------------------------------------------------------
	// Transmit sync pulse
	//--------------------------------------------------------------------------
	// Double width only stretches pulses that open a signalling frame
	wire sync_src = tx_sync_rate_sel ? mframe_start_i : frame_start_i;
	wire sync_dw  = tx_sync_double_wide & sig_frame_i & sync_src;

	// Single bits ride in bit 0 through the byte-wide test forcing
	wire [7:0] fbit_forced = pin_force({7'h00, fbit_sel}, pin_test);
	wire [7:0] sync_forced = pin_force({7'h00, sync_src | sync_ext_q},
	                                   pin_test);

	//--------------------------------------------------------------------------
	// Data output flops, test forcing applied before the flop
	//--------------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_byte_q <= 8'h00;
			line_fbit_q <= 1'b0;
			rx_out_q    <= 8'h00;
			sync_out_q  <= 1'b0;
			sync_ext_q  <= 1'b0;
		end else begin
			if (tx_byte_valid_i) begin
				line_byte_q <= pin_force(fmt_byte, pin_test);
			end
			if (fbit_valid_i) begin
				line_fbit_q <= fbit_forced[0];
			end
			if (rx_take) begin
				rx_out_q <= pin_force(rx_fmt, pin_test);
			end
			sync_ext_q <= sync_dw;
			sync_out_q <= sync_forced[0];
		end
	end

	//--------------------------------------------------------------------------
	// Output pins and enables
	//--------------------------------------------------------------------------
	wire floating = (pin_test == PT_FLOAT);
	assign line_out_byte_o    = line_byte_q;
	assign line_out_fbit_o    = line_fbit_q;
	assign rx_serial_out_o    = rx_out_q;
	assign tx_sync_pin_o      = sync_out_q;
	// Forced levels need the sync pin driven even in input mode
	assign tx_sync_pin_oe_n_o = floating | (~tx_sync_direction &
	                            (pin_test == PT_NORMAL));
	assign tx_sync_in_o       = sync2_q;
	assign out_oe_n_o         = floating;
	assign host_port_oe_n_o   = floating;

	//--------------------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------------------
	property p_bus_ack;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("ack not one cycle");

	property p_write_one;
		@(posedge clk_i) disable iff (rst_i)
		wr_one |=> tcr_one_q == $past(dat_i[7:0]);
	endproperty
	a_write_one: assert property (p_write_one) else $error("write lost");

	property p_fallback;
		@(posedge clk_i) disable iff (rst_i)
		use_rx_clock_o |-> clock_loss_fallback_sel && clk_lost;
	endproperty
	a_fallback: assert property (p_fallback) else $error("bad fallback");

	property p_blue;
		@(posedge clk_i) disable iff (rst_i)
		(tx_byte_valid_i && blue_alarm_send && pin_test == PT_NORMAL)
		|=> line_out_byte_o == 8'hff;
	endproperty
	a_blue: assert property (p_blue) else $error("blue not all ones");

	property p_stuff;
		@(posedge clk_i) disable iff (rst_i)
		(tx_byte_valid_i && !blue_alarm_send && !remote_loop_en_o &&
		 pin_test == PT_NORMAL && zero_suppression_en && global_zero_stuff &&
		 tx_serial_in_i == 8'h00 && !do_sig && !yel_bit2)
		|=> line_out_byte_o == 8'h02;
	endproperty
	a_stuff: assert property (p_stuff) else $error("no bit 7 stuff");

	property p_rx_ones;
		@(posedge clk_i) disable iff (rst_i)
		(rx_take && rx_signalling_force_ones && rx_sig_frame_i &&
		 pin_test == PT_NORMAL) |=> rx_serial_out_o[CH_BIT8_POS];
	endproperty
	a_rx_ones: assert property (p_rx_ones) else $error("sig not forced");

	property p_test_low;
		@(posedge clk_i) disable iff (rst_i)
		(tx_byte_valid_i && pin_test == PT_LOW) |=> line_out_byte_o == 8'h00;
	endproperty
	a_test_low: assert property (p_test_low) else $error("not low");

	property p_float;
		@(posedge clk_i) disable iff (rst_i)
		floating |-> out_oe_n_o && host_port_oe_n_o && tx_sync_pin_oe_n_o;
	endproperty
	a_float: assert property (p_float) else $error("pins not floated");

	property p_sync_dir;
		@(posedge clk_i) disable iff (rst_i)
		(pin_test == PT_NORMAL) |-> tx_sync_pin_oe_n_o == !tx_sync_direction;
	endproperty
	a_sync_dir: assert property (p_sync_dir) else $error("sync dir");

	property p_link;
		@(posedge clk_i) disable iff (rst_i)
		(fbit_valid_i && fbit_kind_i == FB_LINK && !blue_alarm_send &&
		 pin_test == PT_NORMAL) |=> line_out_fbit_o == $past(link_bit);
	endproperty
	a_link: assert property (p_link) else $error("link source");

endmodule

// ==== test/t1tcc_clk_src.sv ====
// Model of the far-side transmit clock source, able to stall
`timescale 1ns/10ps
module t1tcc_clk_src (
	// Control
	input  wire logic run_i,
	// Transmit clock pin
	output logic      pin_o
);
	// Toggles only while running; a stall freezes the pin level
	initial begin
		pin_o = 1'b0;
		forever begin
			#40;
			if (run_i) begin
				pin_o = ~pin_o;
			end
		end
	end
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the transmit and common control bank
`timescale 1ns/10ps
module tb import t1tcc_pkg::*;;
	//--------------------------------------------------------------
	// Signals
	//--------------------------------------------------------------
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, run = 1;
	logic [9:0] adr_i = 0;
	logic [3:0] sel_i = 4'h1;
	logic [31:0] dat_i = 0, dat_o;
	logic [7:0] tx_serial_in_i = 0, rx_line_byte_i = 0, q;
	logic [7:0] line_out_byte_o, rx_serial_out_o;
	logic [1:0] fbit_kind_i = 0;
	wire transmit_clock_i;
	logic ack_o, tx_link_pin_i = 0, tx_sync_pin_i = 0, tx_byte_valid_i = 0;
	logic chan_transparent_i = 0, sig_frame_i = 1, tx_sig_bit_i = 1;
	logic fbit_valid_i = 0, fbit_serial_i = 0, fbit_internal_i = 0;
	logic tx_link_data_reg_i = 0, frame12_i = 0, frame_start_i = 0;
	logic mframe_start_i = 0, rx_byte_valid_i = 0, rx_sig_frame_i = 0;
	logic line_out_fbit_o, tx_sync_pin_o, tx_sync_pin_oe_n_o, tx_sync_in_o;
	logic out_oe_n_o, host_port_oe_n_o, use_rx_clock_o, tx_store_en_o;
	logic tx_slot_interchange_en_o, local_loop_en_o, remote_loop_en_o;
	logic backplane_clock_rate_sel_o;
	int fails = 0, checks_done = 0;
	// Rows: control one, control two, byte, transparent, expected line byte
	logic [39:0] rows [11] = '{40'h0000000000, 40'h0001000002,
		40'h0001000100, 40'h0801000102, 40'h1000800081, 40'h1000800180,
		40'h0100ff00bf, 40'h0102ff00ff, 40'h02000000ff, 40'h0080550000,
		40'h00c05500ff};
	logic [7:0] idx [5] = '{8'h35, 8'h36, 8'h37, 8'h10, 8'h40};

	// Short loss count keeps the stall test brief
	t1tcc_top #(.LOSS_CYCLES(16)) u_t1tcc_top (.*);
	t1tcc_clk_src u_t1tcc_clk_src (.run_i(run), .pin_o(transmit_clock_i));

	always #5 clk_i = ~clk_i;

	//--------------------------------------------------------------
	// Tasks
	//--------------------------------------------------------------
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Classic cycle; ack and read data taken at one rising edge
	task automatic wb(input logic w, input logic [7:0] i, d,
			output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= {i, 2'b00};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		r = dat_o[7:0];
		cyc_i <= 0;
		stb_i <= 0;
		if (n >= 20) begin
			fails++;
			close_out();
		end
	endtask
	task automatic setr(input logic [7:0] a, b, c);
		wb(1, 8'h35, a, q);
		wb(1, 8'h36, b, q);
		wb(1, 8'h37, c, q);
	endtask
	task automatic tx(input logic [7:0] b, input logic t);
		@(posedge clk_i);
		tx_byte_valid_i <= 1;
		tx_serial_in_i <= b;
		chan_transparent_i <= t;
		@(posedge clk_i);
		tx_byte_valid_i <= 0;
		@(negedge clk_i);
	endtask
	// One-cycle frame and multiframe start pulses
	task automatic sp(input logic f, m);
		@(posedge clk_i);
		frame_start_i <= f;
		mframe_start_i <= m;
		@(posedge clk_i);
		frame_start_i <= 0;
		mframe_start_i <= 0;
		@(negedge clk_i);
	endtask
	// Program, send one F-bit of kind k, compare the line F-bit
	task automatic fchk(input logic [7:0] a, b, input logic [1:0] k,
			input logic s, e);
		setr(a, b, 8'h00);
		@(posedge clk_i);
		fbit_valid_i <= 1;
		fbit_kind_i <= k;
		fbit_serial_i <= s;
		@(posedge clk_i);
		fbit_valid_i <= 0;
		@(negedge clk_i);
		chk({7'h0, line_out_fbit_o}, {7'h0, e});
	endtask

	//--------------------------------------------------------------
	// Main sequence
	//--------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		// Reset values, an unmapped index and idle status read zero
		for (int k = 0; k < 5; k++) begin
			wb(0, idx[k], 8'h00, q);
			chk(q, 8'h00);
		end
		$display("test reset done");
		foreach (rows[k]) begin
			setr(rows[k][39:32], rows[k][31:24], 8'h00);
			tx(rows[k][23:16], rows[k][8]);
			chk(line_out_byte_o, rows[k][7:0]);
		end
		$display("test table done");
		setr(8'h00, 8'h40, 8'h00);
		chk({6'h0, out_oe_n_o, host_port_oe_n_o}, 8'h03);
		setr(8'h00, 8'h34, 8'hf8);
		wb(0, 8'h37, 8'h00, q);
		chk(q, 8'hf8);
		chk({3'h0, tx_slot_interchange_en_o, tx_store_en_o, local_loop_en_o,
			remote_loop_en_o, backplane_clock_rate_sel_o}, 8'h1f);
		setr(8'h00, 8'h14, 8'h40);
		chk({3'h0, tx_slot_interchange_en_o, tx_store_en_o, local_loop_en_o,
			remote_loop_en_o, backplane_clock_rate_sel_o}, 8'h04);
		// Double-wide sync pulse in a signalling frame, pin driven
		sp(1'b1, 1'b0);
		chk({6'h0, tx_sync_pin_o, tx_sync_pin_oe_n_o}, 8'h02);
		@(negedge clk_i);
		chk({7'h0, tx_sync_pin_o}, 8'h01);
		@(negedge clk_i);
		chk({7'h0, tx_sync_pin_o}, 8'h00);
		tx(8'h3c, 1'b0);
		chk(rx_serial_out_o, 8'h3c);
		chk(line_out_byte_o, 8'h3c);
		// Multiframe sync ignores frame starts
		setr(8'h00, 8'h0c, 8'h00);
		sp(1'b1, 1'b0);
		chk({7'h0, tx_sync_pin_o}, 8'h00);
		sp(1'b0, 1'b1);
		chk({7'h0, tx_sync_pin_o}, 8'h01);
		// Remote loop with forced receive signalling
		setr(8'h00, 8'h01, 8'h30);
		rx_sig_frame_i <= 1;
		tx(8'hff, 1'b0);
		chk(line_out_byte_o, 8'h00);
		@(posedge clk_i);
		rx_byte_valid_i <= 1;
		@(posedge clk_i);
		rx_byte_valid_i <= 0;
		@(negedge clk_i);
		chk(rx_serial_out_o, 8'h01);
		$display("test controls done");
		// F-bit sources, with link and sync pins held high
		tx_link_pin_i <= 1;
		tx_sync_pin_i <= 1;
		frame12_i <= 1;
		fchk(8'h40, 8'h00, 2'd0, 1'b1, 1'b1);
		fchk(8'h00, 8'h00, 2'd0, 1'b1, 1'b0);
		fchk(8'h20, 8'h00, 2'd1, 1'b1, 1'b1);
		fchk(8'h00, 8'h00, 2'd1, 1'b1, 1'b0);
		fchk(8'h04, 8'h00, 2'd2, 1'b0, 1'b1);
		fchk(8'h00, 8'h00, 2'd2, 1'b0, 1'b0);
		fchk(8'h01, 8'h02, 2'd3, 1'b0, 1'b1);
		fchk(8'h00, 8'h02, 2'd3, 1'b0, 1'b0);
		fchk(8'h02, 8'h00, 2'd0, 1'b0, 1'b1);
		chk({7'h0, tx_sync_in_o}, 8'h01);
		wb(0, 8'h40, 8'h00, q);
		chk(q, 8'h04);
		$display("test fbit done");
		// Stall the transmit clock with fallback armed, then disarm
		setr(8'h80, 8'h00, 8'h00);
		run <= 0;
		repeat (40) @(posedge clk_i);
		chk({7'h0, use_rx_clock_o}, 8'h01);
		setr(8'h00, 8'h00, 8'h00);
		chk({7'h0, use_rx_clock_o}, 8'h00);
		$display("test clock loss done");
		close_out();
	end
endmodule
